// ==== hdl/scrb_regs.svh ====
// Fixed dimensions, encodings and timing figures of the configuration scrubber.
// Assumes it is included by the scrubber package and modules by bare name.
`ifndef SCRB_REGS_SVH
`define SCRB_REGS_SVH

`define SCRB_REGIONS 4
`define SCRB_REGION_W 2
`define SCRB_FRAMES 16
`define SCRB_FRAME_W 4
`define SCRB_LAST_FRAME 4'hf
`define SCRB_CW_W 39
`define SCRB_SYN_W 6
`define SCRB_CRC_W 32
`define SCRB_CRC_INIT 32'hffffffff
`define SCRB_CRC_POLY 32'h04c11db7
`define SCRB_OSC_MHZ 400
`define SCRB_DIV_W 9
`define SCRB_DIV_MIN 9'h001
`define SCRB_DIV_MAX 9'h100

`endif

// ==== hdl/scrb_pkg.sv ====
// Types shared by the scrubber top level and its frame checker.
// Assumes the constants header is available on the include path.
`include "scrb_regs.svh"

package scrb_pkg;

   // One region's slice of a frame read: codeword and exclusion mark.
   typedef struct packed {
      logic user_mem;
      logic [`SCRB_CW_W-1:0] cw;
   } scrb_frame_type;

   typedef scrb_frame_type [`SCRB_REGIONS-1:0] scrb_read_type;

   // Write-back of a repaired codeword.
   typedef struct packed {
      logic en;
      logic [`SCRB_REGION_W-1:0] region;
      logic [`SCRB_FRAME_W-1:0] frame;
      logic [`SCRB_CW_W-1:0] cw;
   } scrb_write_type;

   // Location of the latest single-bit upset.
   typedef struct packed {
      logic [`SCRB_REGION_W-1:0] region;
      logic [`SCRB_FRAME_W-1:0] frame;
      logic [`SCRB_SYN_W-1:0] bit_pos;
   } scrb_loc_type;

   typedef enum logic [2:0] {
      SCRB_IDLE,
      SCRB_REQ,
      SCRB_WAIT,
      SCRB_FIX,
      SCRB_CRC
   } scrb_state_type;

endpackage : scrb_pkg

// ==== hdl/scrb_ecc_check.sv ====
// Single-error-correct, double-error-detect check of one frame codeword.
// Assumes bit 0 is overall parity and bits 1..38 form a Hamming code by position.
`timescale 1ns/1ps
`include "scrb_regs.svh"

module scrb_ecc_check
   import scrb_pkg::*;
(
   input wire logic [`SCRB_CW_W-1:0] cw_in,
   output logic single_out,
   output logic multi_out,
   output logic [`SCRB_SYN_W-1:0] bit_pos_out,
   output logic [`SCRB_CW_W-1:0] corrected_out
);

   logic [`SCRB_SYN_W-1:0] syn;
   logic par;
   logic in_range;

   // Syndrome is the XOR of the positions of all set bits.
   always_comb begin
      syn = '0;
      for (int p = 1; p < `SCRB_CW_W; p++) begin
         if (cw_in[p]) begin
            syn = syn ^ p[`SCRB_SYN_W-1:0];
         end
      end
      par = ^cw_in;
      in_range = (32'(syn) < `SCRB_CW_W);
      // Odd parity with a valid position is one flipped bit; a syndrome
      // pointing past the word can only come from several flips.
      single_out = par && in_range;
      multi_out = (!par && (syn != '0)) || (par && !in_range);
      bit_pos_out = syn;
      corrected_out = cw_in;
      if (single_out) begin
         corrected_out[syn] = ~cw_in[syn];
      end
   end

endmodule : scrb_ecc_check

// ==== hdl/scrb_top.sv ====
// Background scrubber of the configuration memory: frame ECC, repair, bitstream CRC.
// Assumes frame reads answer with cfg_rd_valid_in some cycles after a request,
// and that rst_in comes from the configuration controller alone.
//
// What this block does
// - Reads frames in background, ECC-checks each.
// - Corrects single-bit, detects double-bit frame errors.
// - Single-bit upset flagged, scanning then continues.
// - Correction enabled: rewrite repaired frame codeword.
// - Two bad bits give uncorrectable error.
// - Whole-bitstream CRC checked after all frames.
// - User block memory excluded from ECC, CRC.
// - Four regions are scanned in parallel.
// - Base scrub clock is 400 MHz oscillator.
// - Reset only from configuration controller, none user.
// - Host selects mode, reads status and location.
// - Continuous mode: rescan while enable stays high.
// - Single-pass mode: one scan per rising edge.
// - Scan-active high for whole scan duration.
// - Error flags sticky; enable low clears them.
`timescale 1ns/1ps
`include "scrb_regs.svh"

module scrb_top
   import scrb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic scan_enable_in,
   input wire logic single_pass_in,
   input wire logic correct_enable_in,
   input wire logic [`SCRB_DIV_W-1:0] scrub_clock_divisor_in,
   input wire logic [`SCRB_CRC_W-1:0] golden_crc_in,
   output logic cfg_rd_req_out,
   output logic [`SCRB_FRAME_W-1:0] cfg_rd_frame_out,
   input wire logic cfg_rd_valid_in,
   input wire scrb_read_type cfg_rd_data_in,
   output scrb_write_type cfg_wr_out,
   output logic scan_active_out,
   output logic scan_done_out,
   output logic upset_out,
   output logic multi_bit_error_out,
   output logic crc_error_out,
   output scrb_loc_type err_loc_out
);

   scrb_state_type state_q, state_d;
   logic [`SCRB_FRAME_W-1:0] frame_q, frame_d;
   logic [`SCRB_DIV_W-1:0] div_cnt_q, div_cnt_d;
   logic [`SCRB_CRC_W-1:0] crc_q, crc_d;
   logic [`SCRB_REGIONS-1:0] pend_q, pend_d;
   logic [`SCRB_REGIONS-1:0][`SCRB_CW_W-1:0] fix_cw_q, fix_cw_d;
   logic prev_en_q, prev_en_d;
   logic upset_q, upset_d;
   logic multi_q, multi_d;
   logic crc_err_q, crc_err_d;
   logic done_q, done_d;
   scrb_loc_type loc_q, loc_d;
   scrb_write_type wr_q, wr_d;

   logic [`SCRB_DIV_W-1:0] div_eff;
   logic tick;
   logic start;
   logic fix_found;
   logic [`SCRB_REGIONS-1:0] chk_single;
   logic [`SCRB_REGIONS-1:0] chk_multi;
   logic [`SCRB_REGIONS-1:0][`SCRB_SYN_W-1:0] chk_pos;
   logic [`SCRB_REGIONS-1:0][`SCRB_CW_W-1:0] chk_fixed;

   // Bitwise CRC over one region codeword, most significant bit first.
   function automatic logic [`SCRB_CRC_W-1:0] crc_step(input logic [`SCRB_CRC_W-1:0] c,
                                                        input logic [`SCRB_CW_W-1:0] d);
      logic [`SCRB_CRC_W-1:0] r;
      r = c;
      for (int i = `SCRB_CW_W - 1; i >= 0; i--) begin
         r = {r[`SCRB_CRC_W-2:0], 1'b0} ^ ((r[`SCRB_CRC_W-1] ^ d[i]) ? `SCRB_CRC_POLY : '0);
      end
      return r;
   endfunction : crc_step

   for (genvar g = 0; g < `SCRB_REGIONS; g++) begin : g_chk
      scrb_ecc_check u_chk (
         .cw_in(cfg_rd_data_in[g].cw),
         .single_out(chk_single[g]),
         .multi_out(chk_multi[g]),
         .bit_pos_out(chk_pos[g]),
         .corrected_out(chk_fixed[g])
      );
   end

   // Step pacing models the divided oscillator; the divisor is clamped to
   // its legal span so a stray setting cannot stall the scan.
   // Divisor range honoured.
   always_comb begin
      if (scrub_clock_divisor_in < `SCRB_DIV_MIN) begin
         div_eff = `SCRB_DIV_MIN;
      end else if (scrub_clock_divisor_in > `SCRB_DIV_MAX) begin
         div_eff = `SCRB_DIV_MAX;
      end else begin
         div_eff = scrub_clock_divisor_in;
      end
      tick = (div_cnt_q >= div_eff - `SCRB_DIV_MIN);
   end

   assign start = single_pass_in ? (scan_enable_in && !prev_en_q) : scan_enable_in;

   assign cfg_rd_req_out = (state_q == SCRB_REQ) && tick;
   assign cfg_rd_frame_out = frame_q;
   assign scan_active_out = (state_q != SCRB_IDLE);
   assign scan_done_out = done_q;
   assign upset_out = upset_q;
   assign multi_bit_error_out = multi_q;
   assign crc_error_out = crc_err_q;
   assign err_loc_out = loc_q;
   assign cfg_wr_out = wr_q;

   // Scan sequencer, sticky flags and write-back in one next-state process.
   always_comb begin
      state_d = state_q;
      frame_d = frame_q;
      crc_d = crc_q;
      pend_d = pend_q;
      fix_cw_d = fix_cw_q;
      upset_d = upset_q;
      multi_d = multi_q;
      crc_err_d = crc_err_q;
      loc_d = loc_q;
      done_d = 1'b0;
      wr_d = '0;
      fix_found = 1'b0;
      prev_en_d = scan_enable_in;
      div_cnt_d = tick ? '0 : div_cnt_q + `SCRB_DIV_MIN;
      case (state_q)
         SCRB_IDLE: begin
            div_cnt_d = '0;
            if (start) begin
               frame_d = '0;
               crc_d = `SCRB_CRC_INIT;
               state_d = SCRB_REQ;
            end
         end
         SCRB_REQ: begin
            if (tick) begin
               state_d = SCRB_WAIT;
            end
         end
         SCRB_WAIT: begin
            if (cfg_rd_valid_in) begin
               for (int r = 0; r < `SCRB_REGIONS; r++) begin
                  if (!cfg_rd_data_in[r].user_mem) begin
                     crc_d = crc_step(crc_d, cfg_rd_data_in[r].cw);
                     if (chk_single[r]) begin
                        upset_d = 1'b1;
                        loc_d.region = r[`SCRB_REGION_W-1:0];
                        loc_d.frame = frame_q;
                        loc_d.bit_pos = chk_pos[r];
                        if (correct_enable_in) begin
                           pend_d[r] = 1'b1;
                           fix_cw_d[r] = chk_fixed[r];
                        end
                     end
                     if (chk_multi[r]) begin
                        multi_d = 1'b1;
                     end
                  end
               end
               if (pend_d != '0) begin
                  state_d = SCRB_FIX;
               end else if (frame_q == `SCRB_LAST_FRAME) begin
                  state_d = SCRB_CRC;
               end else begin
                  frame_d = frame_q + 1'b1;
                  state_d = SCRB_REQ;
               end
            end
         end
         SCRB_FIX: begin
            // One repaired region per cycle, lowest region first.
            for (int r = 0; r < `SCRB_REGIONS; r++) begin
               if (pend_q[r] && !fix_found) begin
                  fix_found = 1'b1;
                  pend_d[r] = 1'b0;
                  wr_d.en = 1'b1;
                  wr_d.region = r[`SCRB_REGION_W-1:0];
                  wr_d.frame = frame_q;
                  wr_d.cw = fix_cw_q[r];
               end
            end
            // Scanning resumes at the next frame without rechecking the repair.
            if (pend_d == '0) begin
               if (frame_q == `SCRB_LAST_FRAME) begin
                  state_d = SCRB_CRC;
               end else begin
                  frame_d = frame_q + 1'b1;
                  state_d = SCRB_REQ;
               end
            end
         end
         SCRB_CRC: begin
            if (crc_q != golden_crc_in) begin
               crc_err_d = 1'b1;
            end
            done_d = 1'b1;
            state_d = SCRB_IDLE;
         end
         default: begin
            state_d = SCRB_IDLE;
         end
      endcase
      // Enable low aborts and clears flags. A read landing in that same cycle
      // belongs to the aborted scan and is dropped, so the clear wins on purpose.
      if (!scan_enable_in) begin
         state_d = SCRB_IDLE;
         pend_d = '0;
         upset_d = 1'b0;
         multi_d = 1'b0;
         crc_err_d = 1'b0;
         loc_d = '0;
      end
   end

   // Only the controller reset clears the engine.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_q <= SCRB_IDLE;
         frame_q <= '0;
         div_cnt_q <= '0;
         crc_q <= `SCRB_CRC_INIT;
         pend_q <= '0;
         fix_cw_q <= '0;
         prev_en_q <= 1'b0;
         upset_q <= 1'b0;
         multi_q <= 1'b0;
         crc_err_q <= 1'b0;
         done_q <= 1'b0;
         loc_q <= '0;
         wr_q <= '0;
      end else begin
         state_q <= state_d;
         frame_q <= frame_d;
         div_cnt_q <= div_cnt_d;
         crc_q <= crc_d;
         pend_q <= pend_d;
         fix_cw_q <= fix_cw_d;
         prev_en_q <= prev_en_d;
         upset_q <= upset_d;
         multi_q <= multi_d;
         crc_err_q <= crc_err_d;
         done_q <= done_d;
         loc_q <= loc_d;
         wr_q <= wr_d;
      end
   end

endmodule : scrb_top

// ==== tb/scrb_props.sv ====
// Port checker of the scrubber, bound into scrb_top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`include "scrb_regs.svh"
module scrb_props
   import scrb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic scan_enable_in,
   input wire logic single_pass_in,
   input wire logic cfg_rd_req_out,
   input wire logic [`SCRB_FRAME_W-1:0] cfg_rd_frame_out,
   input wire scrb_write_type cfg_wr_out,
   input wire logic scan_active_out,
   input wire logic scan_done_out,
   input wire logic upset_out,
   input wire logic multi_bit_error_out,
   input wire logic crc_error_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // Each property ties an output to its cause; a scan abort is allowed for everywhere.
   a_req_in_scan: assert property (cfg_rd_req_out |-> scan_active_out)
      else $error("read request outside a scan");
   a_req_once: assert property (cfg_rd_req_out |=> !cfg_rd_req_out)
      else $error("read request held two cycles");
   a_frame_held: assert property (cfg_rd_req_out && scan_enable_in |=> $stable(cfg_rd_frame_out))
      else $error("frame index moved during a read");
   a_done_ends_scan: assert property (scan_done_out |-> $past(scan_active_out) && !scan_active_out
      ##1 !scan_done_out)
      else $error("scan done not a pulse at scan end");
   a_flags_clear: assert property (!scan_enable_in |=> !upset_out && !multi_bit_error_out
      && !crc_error_out && !scan_active_out)
      else $error("flags or scan survive enable low");
   a_upset_sticky: assert property (upset_out && scan_enable_in |=> upset_out)
      else $error("upset flag dropped while enabled");
   a_wr_after_upset: assert property (cfg_wr_out.en && $past(scan_enable_in) |-> upset_out)
      else $error("repair write without an upset");
   a_start_cause: assert property ($rose(scan_active_out) |-> $past(scan_enable_in))
      else $error("scan started without enable");
   a_one_shot: assert property ($rose(scan_active_out) && single_pass_in
      |-> !$past(scan_enable_in, 2))
      else $error("single pass scan without a fresh edge");
   c_done: cover property (scan_done_out);
   c_repair: cover property (cfg_wr_out.en);
   c_multi: cover property (multi_bit_error_out);
   c_crc: cover property (crc_error_out);
endmodule : scrb_props
bind scrb_top scrb_props i_scrb_props (.clk_sys_in, .rst_in, .scan_enable_in, .single_pass_in,
   .cfg_rd_req_out, .cfg_rd_frame_out, .cfg_wr_out, .scan_active_out, .scan_done_out,
   .upset_out, .multi_bit_error_out, .crc_error_out);

// ==== tb/scrb_cfg_model.sv ====
// Behavioural configuration memory answering the scrubber's frame reads.
// Assumes the bench loads mem directly and picks the read latency.
`timescale 1ns/1ps
`include "scrb_regs.svh"
module scrb_cfg_model
   import scrb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [2:0] lat_in,
   input wire logic req_in,
   input wire logic [`SCRB_FRAME_W-1:0] frame_in,
   input wire scrb_write_type wr_in,
   output logic valid_out,
   output scrb_read_type data_out
);
   scrb_frame_type mem [`SCRB_FRAMES][`SCRB_REGIONS];
   logic [2:0] cnt_q;
   logic [`SCRB_FRAME_W-1:0] fr_q;
   // frame answer with user marks.
   // Between answers the data toggles, so a stale word is never taken as fresh.
   always @(posedge clk_sys_in) begin
      valid_out <= 1'b0;
      data_out <= ~data_out;
      if (rst_in) begin
         cnt_q <= 3'h0;
         data_out <= '0;
      end else if (req_in) begin
         fr_q <= frame_in;
         cnt_q <= lat_in;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
         if (cnt_q == 3'h1) begin
            valid_out <= 1'b1;
            for (int i = 0; i < `SCRB_REGIONS; i++) data_out[i] <= mem[fr_q][i];
         end
      end
      if (wr_in.en === 1'b1) mem[wr_in.frame][wr_in.region].cw <= wr_in.cw;
   end
endmodule : scrb_cfg_model

// ==== tb/scrb_top_bench.sv ====
// Self-checking bench of the scrubber against a behavioural memory.
// Assumes the checker binds itself into scrb_top.
`timescale 1ns/1ps
`include "scrb_regs.svh"
module scrb_top_bench
   import scrb_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic scan_enable_in = 1'b0;
   logic single_pass_in = 1'b1;
   logic correct_enable_in = 1'b1;
   logic [`SCRB_DIV_W-1:0] scrub_clock_divisor_in = `SCRB_DIV_MIN;
   logic [`SCRB_CRC_W-1:0] golden_crc_in = '0;
   logic [2:0] lat = 3'h1;
   logic cfg_rd_req_out, cfg_rd_valid_in, scan_active_out, scan_done_out;
   logic upset_out, multi_bit_error_out, crc_error_out;
   logic [`SCRB_FRAME_W-1:0] cfg_rd_frame_out;
   scrb_read_type cfg_rd_data_in;
   scrb_write_type cfg_wr_out;
   scrb_loc_type err_loc_out;
   logic [`SCRB_CW_W-1:0] good, bad;
   integer seed = 90, err_count = 0, compares = 0, req_n = 0, wr_n = 0, f, r, b, b2;
   // Clock period of 100 ns.
   always #50 clk_sys_in = ~clk_sys_in;
   scrb_top i_scrb_top (.clk_sys_in, .rst_in, .scan_enable_in, .single_pass_in,
      .correct_enable_in, .scrub_clock_divisor_in, .golden_crc_in, .cfg_rd_req_out,
      .cfg_rd_frame_out, .cfg_rd_valid_in, .cfg_rd_data_in, .cfg_wr_out, .scan_active_out,
      .scan_done_out, .upset_out, .multi_bit_error_out, .crc_error_out, .err_loc_out);
   scrb_cfg_model i_mem (.clk_sys_in, .rst_in, .lat_in(lat), .req_in(cfg_rd_req_out),
      .frame_in(cfg_rd_frame_out), .wr_in(cfg_wr_out), .valid_out(cfg_rd_valid_in),
      .data_out(cfg_rd_data_in));
   // Reads and repairs are counted mid-cycle, where the comb request has settled.
   always @(negedge clk_sys_in) begin
      if (cfg_rd_req_out === 1'b1) req_n++;
      if (cfg_wr_out.en === 1'b1) wr_n++;
   end
   // Builds a clean codeword: check bits at powers of two, overall parity in bit 0.
   function automatic logic [`SCRB_CW_W-1:0] mk_cw(input logic [`SCRB_CW_W-1:0] v);
      logic [5:0] s;
      s = '0;
      for (int i = 1; i < `SCRB_CW_W; i++) begin
         if ((i & (i - 1)) == 0) v[i] = 1'b0;
         if (v[i]) s ^= i[5:0];
      end
      for (int k = 0; k < 6; k++) v[1 << k] = s[k];
      v[0] = ^v[`SCRB_CW_W-1:1];
      return v;
   endfunction : mk_cw
   // Expected bitstream CRC over unmarked regions, high bit first.
   function automatic logic [31:0] exp_crc();
      logic [31:0] c;
      c = `SCRB_CRC_INIT;
      for (int fi = 0; fi < `SCRB_FRAMES; fi++)
         for (int ri = 0; ri < `SCRB_REGIONS; ri++)
            if (!i_mem.mem[fi][ri].user_mem)
               for (int bi = `SCRB_CW_W - 1; bi >= 0; bi--)
                  c = {c[30:0], 1'b0} ^ ((c[31] ^ i_mem.mem[fi][ri].cw[bi]) ?
                     `SCRB_CRC_POLY : 32'h0);
      return c;
   endfunction : exp_crc
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // A low cycle on enable gives the fresh edge and must leave every flag clear.
   task automatic start_scan();
      @(posedge clk_sys_in) scan_enable_in <= 1'b0;
      @(posedge clk_sys_in) scan_enable_in <= 1'b1;
      req_n = 0;
      wr_n = 0;
      @(negedge clk_sys_in);
      check({upset_out, multi_bit_error_out, crc_error_out, scan_active_out}, 0);
   endtask : start_scan
   task automatic wait_done();
      int n;
      n = 0;
      // At the top divisor one scan takes about 16 x 256 cycles, so the bound leaves room.
      while (scan_done_out !== 1'b1 && n < 6000) begin
         @(negedge clk_sys_in);
         n++;
      end
      if (scan_done_out !== 1'b1) begin
         err_count++;
         results();
      end
   endtask : wait_done
   // Tests: clean with marked region, CRC mismatch at top divisor, repair, double, no repair.
   initial begin
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      for (int t = 0; t < 5; t++) begin
         for (f = 0; f < `SCRB_FRAMES; f++)
            for (r = 0; r < `SCRB_REGIONS; r++)
               i_mem.mem[f][r] = {1'b0, mk_cw(`SCRB_CW_W'({$random(seed), $random(seed)}))};
         f = $unsigned($random(seed)) % `SCRB_FRAMES;
         r = $unsigned($random(seed)) % `SCRB_REGIONS;
         b = $unsigned($random(seed)) % `SCRB_CW_W;
         b2 = (b + 1 + $unsigned($random(seed)) % 38) % `SCRB_CW_W;
         good = i_mem.mem[f][r].cw;
         // Marked junk must be ignored by both checks.
         if (t < 2) i_mem.mem[f][3] = {1'b1, `SCRB_CW_W'({$random(seed), $random(seed)})};
         @(posedge clk_sys_in);
         golden_crc_in <= exp_crc() ^ ((t == 1) ? 32'h1 : 32'h0);
         if (t >= 2) i_mem.mem[f][r].cw[b] ^= 1'b1;
         if (t == 3) i_mem.mem[f][r].cw[b2] ^= 1'b1;
         bad = i_mem.mem[f][r].cw;
         correct_enable_in <= (t != 4);
         // Divisor kept within 1 to 256.
         scrub_clock_divisor_in <= (t == 1) ? `SCRB_DIV_MAX : 9'(1 + $unsigned($random(seed)) % 4);
         lat <= 3'(1 + $unsigned($random(seed)) % 4);
         start_scan();
         wait_done();
         check(scan_active_out, 0);
         if (t < 2) check(crc_error_out, t == 1);
         check(upset_out, t == 2 || t == 4);
         check(multi_bit_error_out, t == 3);
         check(wr_n, t == 2);
         if (t == 2 || t == 4) check(err_loc_out, {r[1:0], f[3:0], b[5:0]});
         check(i_mem.mem[f][r].cw, (t == 2) ? good : bad);
         repeat (20) @(negedge clk_sys_in);
         check(req_n, `SCRB_FRAMES);
         $display("test %0d done", t);
      end
      @(posedge clk_sys_in) single_pass_in <= 1'b0;
      start_scan();
      wait_done();
      @(negedge clk_sys_in);
      wait_done();
      check(req_n, 2 * `SCRB_FRAMES);
      $display("test continuous done");
      results();
   end
endmodule : scrb_top_bench
